/* File: ecc_far_model.sv */
// far side: two timers on the unit clock and the four port pads
// assumes the bench loads and runs the timers and drives the event level
`timescale 1ns/1ps
module ecc_far_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic run_in,
    input wire logic load_in,
    input wire logic [15:0] load_val_in,
    input wire logic first_timer_count_clr_in,
    input wire logic third_timer_count_clr_in,
    input wire logic ext_level_in,
    input wire logic [3:0] drive_in,
    input wire logic [3:0] drive_oe_in,
    output logic [15:0] first_timer_count_out,
    output logic [15:0] third_timer_count_out,
    output logic [3:0] pad_out
);
// timers count on the unit clock only, so never asynchronously
always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        first_timer_count_out <= 16'h0000;
        third_timer_count_out <= 16'h0000;
    end else if (load_in) begin
        first_timer_count_out <= load_val_in;
        third_timer_count_out <= load_val_in ^ 16'h00ff;
    end else begin
        if (first_timer_count_clr_in) first_timer_count_out <= 16'h0000;
        else if (run_in) first_timer_count_out <= first_timer_count_out + 16'h0001;
        if (third_timer_count_clr_in) third_timer_count_out <= 16'h0000;
        else if (run_in) third_timer_count_out <= third_timer_count_out + 16'h0001;
    end
end
// driven pads follow the unit, pad 0 else the outside, others pulled up
assign pad_out = (drive_oe_in & drive_in) |
    (~drive_oe_in & {3'b111, ext_level_in});
endmodule // ecc_far_model

/* File: ecc_pkg.sv */
// constants, register map and carrier types of the capture/compare unit
// assumes one 100 MHz clock shared by the bus, the timers and the unit
//
// What this block does
// - up to four unit outputs, each multiplexed onto a general port pin
// - pin steering: 00xx11xx one pin, 10xx11xx two pins, x1xx11xx four
// - value held as low and high byte; bytes and control readable, writable
// - capture/compare use first or third timer by select bits; pwm second
// - qualifying pin event copies full 16-bit selected timer into the value
// - capture on falling, rising, every 4th or every 16th rising edge
// - each capture sets event flag; only a software write clears it
// - a new capture overwrites an unread value without overrun indication
// - event pin should be input; as output a port write can capture
// - mode change may set a false flag; software masks and clears it
// - prescaler counter cleared when unit off or not in capture mode
// - switching prescaler modes keeps the counter; turn off first
// - compare mode compares 16-bit value with selected timer continuously
// - match drives pin high, low, toggles or leaves it; flag set too
// - clearing control forces compare latch low; port latch untouched
// - flag-only compare mode leaves the pin and only sets the flag
// - special event match emits trigger that resets the selected timer (first or third)
// - 0100 fall, 0101 rise, 0110 every 4th, 0111 every 16th rising edge
// - 0010 toggle, 1000 set, 1001 clear, 1010 flag, 1011 special event
// - mode 0000 turns the unit off and clears latch and prescaler; 0001, 0011 reserved
package ecc_pkg;
    localparam logic [7:0] ECC_OFF_LOW = 8'h00;
    localparam logic [7:0] ECC_OFF_HIGH = 8'h04;
    localparam logic [7:0] ECC_OFF_CTRL = 8'h08;
    localparam logic [7:0] ECC_OFF_STAT = 8'h0c;
    localparam logic [7:0] ECC_OFF_TSEL = 8'h10;
    localparam int ECC_STAT_FLAG_BIT = 0;
    localparam int ECC_STAT_LATCH_BIT = 1;
    localparam logic [7:0] ECC_RST_BYTE = 8'h00;
    localparam logic [1:0] ECC_RST_TSEL = 2'h0;
    localparam logic [3:0] ECC_RST_PORT = 4'h0;
    localparam logic [3:0] ECC_PS4_LAST = 4'h3;
    localparam logic [3:0] ECC_PS16_LAST = 4'hf;
    localparam logic [1:0] ECC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ECC_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ECC_M_OFF = 4'h0, ECC_M_RSV1 = 4'h1, ECC_M_TOGGLE = 4'h2,
        ECC_M_RSV3 = 4'h3, ECC_M_CAP_FALL = 4'h4, ECC_M_CAP_RISE = 4'h5,
        ECC_M_CAP_4 = 4'h6, ECC_M_CAP_16 = 4'h7, ECC_M_SET = 4'h8,
        ECC_M_CLEAR = 4'h9, ECC_M_FLAG = 4'ha, ECC_M_SPECIAL = 4'hb,
        ECC_M_PWM_0 = 4'hc, ECC_M_PWM_1 = 4'hd, ECC_M_PWM_2 = 4'he,
        ECC_M_PWM_3 = 4'hf
    } ecc_mode_e;

    typedef struct packed {
        logic [1:0] output_config_field;
        logic [1:0] duty_low_bits;
        ecc_mode_e mode_select_field;
    } ecc_ctrl_s;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] enable;
    } ecc_pins_s;
endpackage

/* File: ecc_unit.sv */
// capture/compare unit with port pin steering and an AXI4-Lite slave
// assumes timers and port latches on sys_clk_in; pins resolved outside
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ecc_unit #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [15:0] first_timer_count_in,
    input wire logic [15:0] third_timer_count_in,
    input wire logic conv_enable_in,
    input wire logic [3:0] pwm_level_in,
    input wire logic [3:0] port_data_in,
    input wire logic [3:0] port_direction_in,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_out,
    output logic first_timer_reset_out,
    output logic third_timer_reset_out,
    output logic conv_start_out
);

    if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_check
        $error("ecc_unit: ADDR_W must lie in 5..32");
    end

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] low_reg;
    logic [7:0] high_reg;
    ecc_pkg::ecc_ctrl_s ctrl_reg;
    logic [1:0] tsel_reg;
    logic flag_reg;
    logic latch_reg;
    logic [3:0] ps_cnt_reg;
    logic [2:0] pin_sync_reg;
    logic match_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data taken in either order

    logic aw_full_reg;
    logic w_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_go;
    logic [7:0] wr_off;
    logic wr_lane0;
    logic wr_hit;

    assign s_axi_awready_out = !aw_full_reg && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_full_reg && !s_axi_bvalid_out;
    assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid_out;
    assign wr_off = 8'(aw_addr_reg);
    assign wr_lane0 = w_strb_reg[0];
    assign wr_hit = (aw_addr_reg[ADDR_W-1:0] >> 8) == '0 &&
        aw_addr_reg[1:0] == 2'h0 &&
        (wr_off == ecc_pkg::ECC_OFF_LOW || wr_off == ecc_pkg::ECC_OFF_HIGH ||
         wr_off == ecc_pkg::ECC_OFF_CTRL || wr_off == ecc_pkg::ECC_OFF_STAT ||
         wr_off == ecc_pkg::ECC_OFF_TSEL);

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= ecc_pkg::ECC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_hit ? ecc_pkg::ECC_RESP_OKAY :
                    ecc_pkg::ECC_RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_tsel;
    assign wr_low = wr_go && wr_hit && wr_lane0 &&
        wr_off == ecc_pkg::ECC_OFF_LOW;
    assign wr_high = wr_go && wr_hit && wr_lane0 &&
        wr_off == ecc_pkg::ECC_OFF_HIGH;
    assign wr_ctrl = wr_go && wr_hit && wr_lane0 &&
        wr_off == ecc_pkg::ECC_OFF_CTRL;
    assign wr_stat = wr_go && wr_hit && wr_lane0 &&
        wr_off == ecc_pkg::ECC_OFF_STAT;
    assign wr_tsel = wr_go && wr_hit && wr_lane0 &&
        wr_off == ecc_pkg::ECC_OFF_TSEL;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side: one cycle from address to data

    logic [7:0] rd_off;
    logic rd_aligned;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign rd_off = 8'(s_axi_araddr_in);
    assign rd_aligned = (s_axi_araddr_in >> 8) == '0 &&
        s_axi_araddr_in[1:0] == 2'h0;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= ecc_pkg::ECC_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= ecc_pkg::ECC_RESP_OKAY;
            s_axi_rdata_out <= 32'h0000_0000;
            if (!rd_aligned) begin
                s_axi_rresp_out <= ecc_pkg::ECC_RESP_SLVERR;
            end else if (rd_off == ecc_pkg::ECC_OFF_LOW) begin
                s_axi_rdata_out <= {24'h00_0000, low_reg};
            end else if (rd_off == ecc_pkg::ECC_OFF_HIGH) begin
                s_axi_rdata_out <= {24'h00_0000, high_reg};
            end else if (rd_off == ecc_pkg::ECC_OFF_CTRL) begin
                s_axi_rdata_out <= {24'h00_0000, ctrl_reg};
            end else if (rd_off == ecc_pkg::ECC_OFF_STAT) begin
                s_axi_rdata_out <= {30'h0000_0000, latch_reg, flag_reg};
            end else if (rd_off == ecc_pkg::ECC_OFF_TSEL) begin
                s_axi_rdata_out <= {30'h0000_0000, tsel_reg};
            end else begin
                s_axi_rresp_out <= ecc_pkg::ECC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode, timer select and event detection

    ecc_pkg::ecc_mode_e mode;
    logic is_capture;
    logic is_compare;
    logic is_pwm;
    logic [15:0] timer_sel;
    logic [15:0] value;
    logic pin_rise;
    logic pin_fall;
    logic cap_event;
    logic match_now;
    logic match_event;

    assign mode = ctrl_reg.mode_select_field;
    assign is_capture = mode[3:2] == 2'h1;
    assign is_pwm = mode[3:2] == 2'h3;
    assign is_compare = mode == ecc_pkg::ECC_M_TOGGLE ||
        mode[3:2] == 2'h2;
    assign timer_sel = tsel_reg == 2'h0 ? first_timer_count_in :
        third_timer_count_in;
    assign value = {high_reg, low_reg};
    // stage 0 only feeds stage 1; edges are seen between stages 1 and 2
    assign pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];
    assign pin_fall = !pin_sync_reg[1] && pin_sync_reg[2];
    assign match_now = is_compare && value == timer_sel;
    // a slow timer sits on one value many cycles; act on arrival only
    assign match_event = match_now && !match_prev_reg;

    always_comb begin
        cap_event = 1'b0;
        unique case (mode)
            ecc_pkg::ECC_M_CAP_FALL: cap_event = pin_fall;
            ecc_pkg::ECC_M_CAP_RISE: cap_event = pin_rise;
            ecc_pkg::ECC_M_CAP_4:
                cap_event = pin_rise && ps_cnt_reg[1:0] ==
                    ecc_pkg::ECC_PS4_LAST[1:0];
            ecc_pkg::ECC_M_CAP_16:
                cap_event = pin_rise &&
                    ps_cnt_reg == ecc_pkg::ECC_PS16_LAST;
            default: cap_event = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_sync_reg <= 3'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], pin_in[0]};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ps_cnt_reg <= 4'h0;
        end else if (!is_capture) begin
            ps_cnt_reg <= 4'h0;
        end else if (pin_rise && (mode == ecc_pkg::ECC_M_CAP_4 ||
                mode == ecc_pkg::ECC_M_CAP_16)) begin
            // counter is kept across prescaler changes inside capture
            ps_cnt_reg <= cap_event ? 4'h0 : ps_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            match_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers; a capture beats a same-cycle byte write

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            low_reg <= ecc_pkg::ECC_RST_BYTE;
            high_reg <= ecc_pkg::ECC_RST_BYTE;
        end else if (cap_event) begin
            low_reg <= timer_sel[7:0];
            high_reg <= timer_sel[15:8];
        end else begin
            if (wr_low) begin
                low_reg <= w_data_reg[7:0];
            end
            if (wr_high) begin
                high_reg <= w_data_reg[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_reg <= ecc_pkg::ecc_ctrl_s'(ecc_pkg::ECC_RST_BYTE);
            tsel_reg <= ecc_pkg::ECC_RST_TSEL;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= ecc_pkg::ecc_ctrl_s'(w_data_reg[7:0]);
            end
            if (wr_tsel) begin
                tsel_reg <= w_data_reg[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_reg <= 1'b0;
        end else if (cap_event || match_event) begin
            flag_reg <= 1'b1;
        end else if (wr_stat && w_data_reg[ecc_pkg::ECC_STAT_FLAG_BIT]) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            latch_reg <= 1'b0;
        end else if (mode == ecc_pkg::ECC_M_OFF) begin
            latch_reg <= 1'b0;
        end else if (match_event) begin
            unique case (mode)
                ecc_pkg::ECC_M_TOGGLE: latch_reg <= !latch_reg;
                ecc_pkg::ECC_M_SET: latch_reg <= 1'b1;
                ecc_pkg::ECC_M_CLEAR: latch_reg <= 1'b0;
                default: latch_reg <= latch_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // special event trigger and pin steering

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            first_timer_reset_out <= 1'b0;
            third_timer_reset_out <= 1'b0;
            conv_start_out <= 1'b0;
        end else begin
            first_timer_reset_out <= match_event &&
                mode == ecc_pkg::ECC_M_SPECIAL && tsel_reg == 2'h0;
            third_timer_reset_out <= match_event &&
                mode == ecc_pkg::ECC_M_SPECIAL && tsel_reg != 2'h0;
            conv_start_out <= match_event && conv_enable_in &&
                mode == ecc_pkg::ECC_M_SPECIAL;
        end
    end

    ecc_pkg::ecc_pins_s pins;
    logic [3:0] owned;
    logic [3:0] unit_level;

    always_comb begin
        owned = 4'h0;
        unit_level = pwm_level_in;
        if (is_pwm) begin
            owned = 4'h1;
            if (ctrl_reg.output_config_field[0]) begin
                owned = 4'hf;
            end else if (ctrl_reg.output_config_field[1]) begin
                owned = 4'h3;
            end
        end else if (is_compare) begin
            owned = 4'h1;
            unit_level[0] = latch_reg;
        end
        // the port latch itself is never touched, only bypassed
        pins.level = (owned & unit_level) | (~owned & port_data_in);
        pins.enable = ~port_direction_in;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_out <= ecc_pkg::ECC_RST_PORT;
            pin_oe_out <= ecc_pkg::ECC_RST_PORT;
        end else begin
            pin_out <= pins.level;
            pin_oe_out <= pins.enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    prescale_clear_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) !is_capture |=> ps_cnt_reg == 4'h0)
        else $error("prescaler not cleared outside capture");
    capture_copy_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        cap_event |=> value == $past(timer_sel))
        else $error("capture did not copy selected timer");
    flag_set_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) cap_event || match_event |=> flag_reg)
        else $error("event did not set flag");
    flag_hold_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        flag_reg && !wr_stat |=> flag_reg)
        else $error("flag cleared without software write");
    off_latch_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        mode == ecc_pkg::ECC_M_OFF |=> !latch_reg)
        else $error("compare latch not low while off");
    set_match_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        match_event && mode == ecc_pkg::ECC_M_SET |=> latch_reg)
        else $error("set on match failed");
    toggle_match_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        match_event && mode == ecc_pkg::ECC_M_TOGGLE
        |=> latch_reg != $past(latch_reg))
        else $error("toggle on match failed");
    flag_only_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        mode == ecc_pkg::ECC_M_FLAG && $past(mode) == ecc_pkg::ECC_M_FLAG
        |-> $stable(latch_reg))
        else $error("flag-only mode moved the latch");
    special_trig_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        match_event && mode == ecc_pkg::ECC_M_SPECIAL && tsel_reg == 2'h0
        |=> first_timer_reset_out ##1 !first_timer_reset_out)
        else $error("special trigger not a single pulse");
    rise_sixteen_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        mode == ecc_pkg::ECC_M_CAP_16 && pin_rise
        |=> ps_cnt_reg == $past(ps_cnt_reg) + 4'h1)
        else $error("sixteenth edge capture at wrong count");
    quad_steer_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        is_pwm && ctrl_reg.output_config_field[0]
        |=> pin_out == $past(pwm_level_in))
        else $error("quad steering did not pass all outputs");

    capture_seen_c: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) cap_event ##[1:50] cap_event);
    toggle_seen_c: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        match_event && mode == ecc_pkg::ECC_M_TOGGLE);
    special_seen_c: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) first_timer_reset_out);
    set_clear_race_c: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) cap_event && wr_stat);

endmodule // ecc_unit

/* File: tb_top.sv */
// directed bench for the capture/compare unit over its register bus
// assumes the far model supplies timers and pads on one 100 MHz clock
`timescale 1ns/1ps
module tb_top;
logic clk, rst_b, awv, wv, arv, ld, run, ext, conv, awr, wrr, bv, arr, rv;
logic t1r, t3r, cst;
logic [7:0] awa, ara;
logic [31:0] wd, rdata;
logic [3:0] pwm, pdat, pdir, pin_o, pin_oe, pin_i;
logic [1:0] bresp, rresp;
logic [15:0] t1, t3, lv;
int err_total, n_tests, cyc, n, c;
ecc_unit dut (.sys_clk_in(clk), .rst_b_in(rst_b), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1),
    .first_timer_count_in(t1), .third_timer_count_in(t3),
    .conv_enable_in(conv), .pwm_level_in(pwm), .port_data_in(pdat),
    .port_direction_in(pdir), .pin_in(pin_i), .pin_out(pin_o),
    .pin_oe_out(pin_oe), .first_timer_reset_out(t1r),
    .third_timer_reset_out(t3r), .conv_start_out(cst));
ecc_far_model far (.clk_in(clk), .rst_b_in(rst_b), .run_in(run),
    .load_in(ld), .load_val_in(lv), .first_timer_count_clr_in(t1r), .third_timer_count_clr_in(t3r),
    .ext_level_in(ext), .drive_in(pin_o), .drive_oe_in(pin_oe),
    .first_timer_count_out(t1), .third_timer_count_out(t3), .pad_out(pin_i));
////////////////////////////////////////////////////////////////////////////
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
        err_total++;
        test_done();
    end
end
task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
        err_total++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// ready is sampled mid-cycle, so the handshake edge is the next rise
task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
        @(negedge clk);
        ha = awv & awr;
        hw = wv & wrr;
        hb = bv;
        r = bresp;
        @(posedge clk);
        if (ha) awv <= 1'b0;
        if (hw) wv <= 1'b0;
    end while (!hb);
    chk({30'h0, r}, {30'h0, er});
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    ara <= a;
    arv <= 1'b1;
    do begin
        @(negedge clk);
        ha = arv & arr;
        hr = rv;
        d = rdata;
        r = rresp;
        @(posedge clk);
        if (ha) arv <= 1'b0;
    end while (!hr);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
endtask
task automatic pulses(input int k);
    repeat (k) begin
        ext <= 1'b1;
        repeat (5) @(posedge clk);
        ext <= 1'b0;
        repeat (5) @(posedge clk);
    end
endtask
task automatic ldt(input logic [15:0] v);
    lv <= v;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    logic [3:0] md [4] = '{4'h8, 4'h9, 4'h2, 4'ha};
    logic [3:0] ql [4] = '{4'h1, 4'h0, 4'h1, 4'h1};
    logic [7:0] pc [3] = '{8'h0c, 8'h8c, 8'h4c};
    logic [3:0] pq [3] = '{4'h4, 4'h6, 4'ha};
    {rst_b, awv, wv, arv, ld, run, ext, conv} = 8'h00;
    {awa, ara, wd, lv} = 64'h0;
    {pwm, pdat, pdir} = 12'ha5f;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h08, 32'h0, 2'h0);
    wr(8'h00, 8'ha5, 2'h0);
    wr(8'h04, 8'h3c, 2'h0);
    wr(8'h08, 8'h30, 2'h0);
    rd(8'h00, 32'ha5, 2'h0);
    rd(8'h04, 32'h3c, 2'h0);
    rd(8'h08, 32'h30, 2'h0);
    wr(8'h14, 8'hff, 2'h2);
    rd(8'h14, 32'h0, 2'h2);
    ldt(16'h1234);
    wr(8'h08, 8'h05, 2'h0);
    wr(8'h0c, 8'h01, 2'h0);
    pulses(1);
    rd(8'h00, 32'h34, 2'h0);
    rd(8'h04, 32'h12, 2'h0);
    ldt(16'h4321);
    pulses(1);
    rd(8'h0c, 32'h1, 2'h0);
    rd(8'h00, 32'h21, 2'h0);
    wr(8'h0c, 8'h01, 2'h0);
    rd(8'h0c, 32'h0, 2'h0);
    wr(8'h10, 8'h01, 2'h0);
    ldt(16'h0f0f);
    pulses(1);
    rd(8'h00, 32'hf0, 2'h0);
    rd(8'h04, 32'h0f, 2'h0);
    wr(8'h10, 8'h00, 2'h0);
    wr(8'h08, 8'h04, 2'h0);
    wr(8'h0c, 8'h01, 2'h0);
    ext <= 1'b1;
    repeat (5) @(posedge clk);
    rd(8'h0c, 32'h0, 2'h0);
    ext <= 1'b0;
    repeat (5) @(posedge clk);
    rd(8'h0c, 32'h1, 2'h0);
    wr(8'h08, 8'h06, 2'h0);
    pulses(2);
    wr(8'h08, 8'h00, 2'h0);
    wr(8'h08, 8'h06, 2'h0);
    wr(8'h0c, 8'h01, 2'h0);
    pulses(3);
    rd(8'h0c, 32'h0, 2'h0);
    pulses(1);
    rd(8'h0c, 32'h1, 2'h0);
    wr(8'h08, 8'h07, 2'h0);
    wr(8'h0c, 8'h01, 2'h0);
    pulses(15);
    rd(8'h0c, 32'h0, 2'h0);
    pulses(1);
    rd(8'h0c, 32'h1, 2'h0);
    // compare drives pad 0, so its direction bit goes to output
    pdir <= 4'h0;
    run <= 1'b1;
    wr(8'h00, 8'h10, 2'h0);
    wr(8'h04, 8'h00, 2'h0);
    for (int i = 0; i < 4; i++) begin
        wr(8'h08, {4'h0, md[i]}, 2'h0);
        wr(8'h0c, 8'h01, 2'h0);
        ldt(16'h0000);
        repeat (40) @(posedge clk);
        rd(8'h0c, {30'h0, ql[i][0], 1'b1}, 2'h0);
        chk({31'h0, pin_o[0]}, {31'h0, ql[i][0]});
    end
    wr(8'h08, 8'h00, 2'h0);
    rd(8'h0c, 32'h1, 2'h0);
    chk({31'h0, pin_o[0]}, {31'h0, pdat[0]});
    conv <= 1'b1;
    wr(8'h00, 8'h20, 2'h0);
    wr(8'h08, 8'h0b, 2'h0);
    ldt(16'h0000);
    repeat (100) begin
        @(negedge clk);
        n += int'(t1r);
        c += int'(cst) + int'(t3r);
    end
    chk(32'(t1 <= 16'h0022), 32'h1);
    @(posedge clk);
    chk(32'(n >= 2), 32'h1);
    chk(32'(c), 32'(n));
    for (int i = 0; i < 3; i++) begin
        wr(8'h08, pc[i], 2'h0);
        repeat (2) @(posedge clk);
        chk({28'h0, pin_o}, {28'h0, pq[i]});
        chk({28'h0, pin_oe}, 32'hf);
    end
    test_done();
end
endmodule // tb_top
